/* File: design/core_mem_org.sv */
// Core memory organisation: PC, return stack, pointers, banked data space, status
`timescale 1ns/100ps

// Summary of operation
// RULE_01 - Program counter is 15 bits; addresses wrap into 2048 implemented words.
// RULE_02 - Reset starts fetch at 0000h; interrupt vectors to 0004h.
// RULE_03 - Return stack holds 16 entries of 15 bits apart from data memory.
// RULE_04 - Push past 16 sets overflow, empty pop sets underflow; optional reset.
// RULE_05 - Two 16-bit pointers reach all file registers and program memory.
// RULE_06 - Pointer high bit 7 set reads program memory, low byte returned.
// RULE_07 - Indirect program memory reads take one extra instruction cycle.
// RULE_08 - Indirect writes aimed at program memory change nothing.
// RULE_09 - Data space is 32 banks of 128 bytes with four regions each.
// RULE_10 - Direct addressing bank comes from the bank select register.
// RULE_11 - Unimplemented data locations read as zero.
// RULE_12 - Data addresses are 12 bits of bank and offset.
// RULE_13 - Twelve core registers appear at offsets 0 to 0Bh of every bank.
// RULE_14 - Peripheral registers sit at offsets 0Ch to 1Fh in each bank.
// RULE_15 - Up to 80 general RAM bytes per bank, also reachable linearly.
// RULE_16 - Sixteen common RAM bytes are shared by all banks.
// RULE_17 - Status writes by flag-setting ops leave zero, digit and carry to ALU.
// RULE_18 - Timeout and power-down are read-only; status bits 7-5 read zero.
// RULE_19 - Timeout and power-down flags follow power-up, watchdog clear, sleep, timeout.
// RULE_20 - Zero flag reflects a zero arithmetic or logic result.
// RULE_21 - Digit carry from bit 3, carry from bit 7 on add and subtract.
// RULE_22 - Subtract adds two's complement; rotates load carry with shifted bit.
// RULE_23 - Bank is upper 5 bits, offset lower 7 bits of data address.
// RULE_24 - Power-on reset sets timeout and power-down, clears arithmetic flags.
module core_mem_org #(
    parameter int RAM_BANKS = 1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    input wire logic POR,
    // Program flow control
    input wire logic PC_ADVANCE,
    input wire logic PC_LOAD,
    input wire logic [14:0] PC_TARGET,
    input wire logic INT_TAKE,
    input wire logic CALL_PUSH,
    input wire logic RET_POP,
    input wire logic STACK_RESET_EN,
    output logic [14:0] PC,
    output logic STACK_OVF,
    output logic STACK_UNF,
    output logic SOFT_RESET,
    // Data access
    input wire core_mem_pkg::data_req_s DREQ,
    output logic [7:0] RDATA,
    output logic STALL,
    // Program memory read port for indirect fetch
    output logic PROG_RD,
    output logic [14:0] PROG_ADDR,
    input wire logic [13:0] PROG_DATA,
    // Peripheral register window
    output logic PERIPH_WR,
    output logic [11:0] PERIPH_ADDR,
    output logic [7:0] PERIPH_WDATA,
    input wire logic [7:0] PERIPH_RDATA,
    // Arithmetic flags and power events
    input wire core_mem_pkg::alu_req_s ALU,
    input wire logic CLR_WDT,
    input wire logic SLEEP,
    input wire logic WDT_TIMEOUT,
    output logic [7:0] STATUS
);
    logic [14:0] pc_reg;
    logic [14:0] stack_mem [core_mem_pkg::STACK_DEPTH];
    logic [4:0] sp_reg;
    logic ovf_reg;
    logic unf_reg;
    logic soft_reg;
    logic [7:0] ptr_lo [2];
    logic [7:0] ptr_hi [2];
    logic [7:0] bank_reg;
    logic [7:0] accum_reg;
    logic [7:0] latch_reg;
    logic [7:0] intc_reg;
    logic [7:0] status_reg;
    logic [7:0] ram [RAM_BANKS * core_mem_pkg::RAM_BYTES];
    logic [7:0] common [core_mem_pkg::COMMON_BYTES];
    logic [7:0] rdata_reg;
    logic stall_reg;
    logic prog_wait_reg;
    logic [11:0] daddr;
    logic [15:0] ptr;
    logic to_prog;
    logic [6:0] ofs;
    logic [4:0] bank;
    logic [7:0] sum;
    logic c_out;
    logic dc_out;
    logic [7:0] alu_res;
    logic flag_op;

    // Fold any 15-bit address into implemented space
    function automatic logic [14:0] wrap(input logic [14:0] a);
        return a & core_mem_pkg::PROG_LAST; // RULE_01
    endfunction

    // Index into banked general RAM; -1 when unimplemented
    function automatic int ram_index(input logic [4:0] b, input logic [6:0] o);
        if (o < core_mem_pkg::OFS_RAM_FIRST || o > core_mem_pkg::OFS_RAM_LAST
            || int'(b) >= RAM_BANKS)
            return -1;
        return int'(b) * core_mem_pkg::RAM_BYTES + int'(o - core_mem_pkg::OFS_RAM_FIRST);
    endfunction

    // Address formation
    always_comb
    begin
        ptr = {ptr_hi[DREQ.ptr_sel], ptr_lo[DREQ.ptr_sel]}; // RULE_05
        to_prog = DREQ.indirect && ptr[15];
        if (DREQ.indirect)
            daddr = ptr[11:0];
        else
            daddr = {bank_reg[4:0], DREQ.ofs}; // RULE_10 RULE_12
        bank = daddr[11:7]; // RULE_23
        ofs = daddr[6:0];
        // Linear window: 2000h to 2FFFh maps 80-byte slices bank by bank
        if (DREQ.indirect && !ptr[15] && ptr[15:12] == core_mem_pkg::LINEAR_TOP)
        begin
            bank = 5'(ptr[11:0] / 12'(core_mem_pkg::RAM_BYTES)); // RULE_15
            ofs = 7'(ptr[11:0] % 12'(core_mem_pkg::RAM_BYTES)) + core_mem_pkg::OFS_RAM_FIRST;
        end
    end

    // ALU flag outcome
    always_comb
    begin
        logic [8:0] wide;
        logic [4:0] nib;
        logic [7:0] bop;
        wide = '0;
        nib = '0;
        bop = (ALU.op == core_mem_pkg::OP_SUB) ? 8'(~ALU.b + 8'h01) : ALU.b; // RULE_22
        wide = {1'b0, ALU.a} + {1'b0, bop};
        nib = {1'b0, ALU.a[3:0]} + {1'b0, bop[3:0]};
        if (ALU.op == core_mem_pkg::OP_SUB && ALU.b == 8'h00)
            wide[8] = 1'b1;
        if (ALU.op == core_mem_pkg::OP_SUB && ALU.b[3:0] == 4'h0)
            nib[4] = 1'b1;
        sum = wide[7:0];
        c_out = wide[8]; // RULE_21
        dc_out = nib[4];
        unique case (ALU.op)
            core_mem_pkg::OP_ROT_LEFT: c_out = ALU.a[7]; // RULE_22
            core_mem_pkg::OP_ROT_RIGHT: c_out = ALU.a[0];
            default: ;
        endcase
        alu_res = (ALU.op == core_mem_pkg::OP_LOGIC) ? ALU.b : sum;
        flag_op = ALU.op != core_mem_pkg::OP_NONE;
    end

    // Program counter
    always_ff @(posedge CLK)
    begin
        if (RST)
            pc_reg <= core_mem_pkg::RESET_VECTOR; // RULE_02
        else if (stall_reg)
            pc_reg <= pc_reg; // RULE_07
        else if (INT_TAKE)
            pc_reg <= core_mem_pkg::INT_VECTOR; // RULE_02
        else if (RET_POP && sp_reg != 5'h00)
            pc_reg <= stack_mem[4'(sp_reg - 5'h01)];
        else if (PC_LOAD)
            pc_reg <= wrap(PC_TARGET);
        else if (PC_ADVANCE)
            pc_reg <= wrap(pc_reg + 15'h0001); // RULE_01
    end

    // Return stack
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sp_reg <= '0;
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
        end
        else if ((CALL_PUSH || INT_TAKE) && !stall_reg)
        begin
            if (sp_reg == 5'(core_mem_pkg::STACK_DEPTH))
                ovf_reg <= 1'b1; // RULE_04
            else
            begin
                stack_mem[sp_reg[3:0]] <= PC_ADVANCE ? wrap(pc_reg + 15'h0001) : pc_reg; // RULE_03
                sp_reg <= sp_reg + 5'h01;
            end
        end
        else if (RET_POP && !stall_reg)
        begin
            if (sp_reg == 5'h00)
                unf_reg <= 1'b1; // RULE_04
            else
                sp_reg <= sp_reg - 5'h01;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            soft_reg <= 1'b0;
        else
            soft_reg <= STACK_RESET_EN && (ovf_reg || unf_reg) && !soft_reg; // RULE_04
    end

    // Indirect program fetch wait
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            stall_reg <= 1'b0;
            prog_wait_reg <= 1'b0;
        end
        else
        begin
            prog_wait_reg <= DREQ.rd && to_prog && !prog_wait_reg; // RULE_07
            stall_reg <= DREQ.rd && to_prog && !prog_wait_reg;
        end
    end

    // Core registers
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ptr_lo[0] <= '0;
            ptr_lo[1] <= '0;
            ptr_hi[0] <= '0;
            ptr_hi[1] <= '0;
            bank_reg <= '0;
            accum_reg <= '0;
            latch_reg <= '0;
            intc_reg <= '0;
        end
        else if (DREQ.wr && !to_prog) // RULE_08
        begin
            unique case (ofs) // RULE_13
                core_mem_pkg::OFS_PTR0_LOW: ptr_lo[0] <= DREQ.wdata;
                core_mem_pkg::OFS_PTR0_HIGH: ptr_hi[0] <= DREQ.wdata;
                core_mem_pkg::OFS_PTR1_LOW: ptr_lo[1] <= DREQ.wdata;
                core_mem_pkg::OFS_PTR1_HIGH: ptr_hi[1] <= DREQ.wdata;
                core_mem_pkg::OFS_BANK_SEL: bank_reg <= {3'h0, DREQ.wdata[4:0]};
                core_mem_pkg::OFS_ACCUM: accum_reg <= DREQ.wdata;
                core_mem_pkg::OFS_PC_LATCH: latch_reg <= {1'b0, DREQ.wdata[6:0]};
                core_mem_pkg::OFS_INT_CTRL: intc_reg <= DREQ.wdata;
                default: ;
            endcase
        end
    end

    // Status register
    always_ff @(posedge CLK)
    begin
        if (POR)
            status_reg <= core_mem_pkg::STATUS_POR; // RULE_24
        else
        begin
            if (DREQ.wr && !to_prog && ofs == core_mem_pkg::OFS_STATUS && !flag_op)
                status_reg[2:0] <= DREQ.wdata[2:0]; // RULE_17
            if (flag_op)
            begin
                status_reg[core_mem_pkg::ST_ZERO] <= alu_res == 8'h00; // RULE_20
                if (ALU.op == core_mem_pkg::OP_ADD || ALU.op == core_mem_pkg::OP_SUB)
                    status_reg[core_mem_pkg::ST_DIGIT] <= dc_out; // RULE_21
                if (ALU.op != core_mem_pkg::OP_LOGIC)
                    status_reg[core_mem_pkg::ST_CARRY] <= c_out;
            end
            if (WDT_TIMEOUT)
                status_reg[core_mem_pkg::ST_TIMEOUT] <= 1'b0; // RULE_19
            else if (CLR_WDT || SLEEP)
                status_reg[core_mem_pkg::ST_TIMEOUT] <= 1'b1;
            if (CLR_WDT)
                status_reg[core_mem_pkg::ST_POWERDOWN] <= 1'b1;
            else if (SLEEP)
                status_reg[core_mem_pkg::ST_POWERDOWN] <= 1'b0;
            status_reg[7:5] <= 3'h0; // RULE_18
        end
    end

    // General and common RAM
    always_ff @(posedge CLK)
    begin
        int idx;
        idx = ram_index(bank, ofs);
        if (DREQ.wr && !to_prog && !RST)
        begin
            if (ofs >= core_mem_pkg::OFS_COMMON_FIRST)
                common[ofs[3:0]] <= DREQ.wdata; // RULE_16
            else if (idx >= 0)
                ram[idx] <= DREQ.wdata; // RULE_09 RULE_15
        end
    end

    // Read mux
    always_ff @(posedge CLK)
    begin
        int idx;
        idx = ram_index(bank, ofs);
        if (RST)
            rdata_reg <= '0;
        else if (prog_wait_reg)
            rdata_reg <= PROG_DATA[7:0]; // RULE_06
        else if (DREQ.rd && !to_prog)
        begin
            if (ofs >= core_mem_pkg::OFS_COMMON_FIRST)
                rdata_reg <= common[ofs[3:0]];
            else if (ofs >= core_mem_pkg::OFS_RAM_FIRST)
                rdata_reg <= (idx >= 0) ? ram[idx] : 8'h00; // RULE_11
            else if (ofs >= core_mem_pkg::OFS_PERIPH_FIRST)
                rdata_reg <= PERIPH_RDATA; // RULE_14
            else
            begin
                unique case (ofs)
                    core_mem_pkg::OFS_PC_LOW: rdata_reg <= pc_reg[7:0];
                    core_mem_pkg::OFS_STATUS: rdata_reg <= status_reg;
                    core_mem_pkg::OFS_PTR0_LOW: rdata_reg <= ptr_lo[0];
                    core_mem_pkg::OFS_PTR0_HIGH: rdata_reg <= ptr_hi[0];
                    core_mem_pkg::OFS_PTR1_LOW: rdata_reg <= ptr_lo[1];
                    core_mem_pkg::OFS_PTR1_HIGH: rdata_reg <= ptr_hi[1];
                    core_mem_pkg::OFS_BANK_SEL: rdata_reg <= bank_reg;
                    core_mem_pkg::OFS_ACCUM: rdata_reg <= accum_reg;
                    core_mem_pkg::OFS_PC_LATCH: rdata_reg <= latch_reg;
                    core_mem_pkg::OFS_INT_CTRL: rdata_reg <= intc_reg;
                    default: rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    // Program read and peripheral ports, registered
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            PROG_RD <= 1'b0;
            PROG_ADDR <= '0;
            PERIPH_WR <= 1'b0;
            PERIPH_ADDR <= '0;
            PERIPH_WDATA <= '0;
        end
        else
        begin
            PROG_RD <= DREQ.rd && to_prog && !prog_wait_reg;
            PROG_ADDR <= wrap(ptr[14:0]); // RULE_06
            PERIPH_WR <= DREQ.wr && !to_prog && ofs >= core_mem_pkg::OFS_PERIPH_FIRST
                && ofs <= core_mem_pkg::OFS_PERIPH_LAST;
            PERIPH_ADDR <= {bank, ofs};
            PERIPH_WDATA <= DREQ.wdata;
        end
    end

    assign PC = pc_reg;
    assign STACK_OVF = ovf_reg;
    assign STACK_UNF = unf_reg;
    assign SOFT_RESET = soft_reg;
    assign RDATA = rdata_reg;
    assign STALL = stall_reg;
    assign STATUS = status_reg;

    // Checks
    pc_reset_a: assert property (@(posedge CLK) RST |=> PC == 15'h0000) // RULE_02
        else $error("pc not at reset vector");
    pc_int_a: assert property (@(posedge CLK) disable iff (RST)
        INT_TAKE && !STALL |=> PC == 15'h0004) // RULE_02
        else $error("interrupt vector wrong");
    pc_range_a: assert property (@(posedge CLK) disable iff (RST) PC[14:11] == 4'h0) // RULE_01
        else $error("pc outside program space");
    stack_ovf_a: assert property (@(posedge CLK) disable iff (RST)
        CALL_PUSH && !INT_TAKE && !STALL && sp_reg == 5'd16 |=> STACK_OVF) // RULE_04
        else $error("overflow not flagged");
    stack_unf_a: assert property (@(posedge CLK) disable iff (RST)
        RET_POP && !CALL_PUSH && !INT_TAKE && !STALL && sp_reg == 5'd0 |=> STACK_UNF) // RULE_04
        else $error("underflow not flagged");
    status_top_a: assert property (@(posedge CLK) disable iff (POR)
        ##1 STATUS[7:5] == 3'h0) // RULE_18
        else $error("status upper bits set");
    prog_stall_a: assert property (@(posedge CLK) disable iff (RST)
        DREQ.rd && DREQ.indirect && ptr[15] && !STALL |=> STALL ##1 !STALL) // RULE_07
        else $error("program read stall wrong");
    zero_flag_a: assert property (@(posedge CLK) disable iff (POR)
        ALU.op == core_mem_pkg::OP_LOGIC && ALU.b == 8'h00 |=> STATUS[2]) // RULE_20
        else $error("zero flag not set");
endmodule

/* File: design/core_mem_pkg.sv */
// Package of constants and carrier types for the core memory organisation block
package core_mem_pkg;
    // Program space
    localparam int PC_W = 15;
    localparam int PROG_WORDS = 2048;
    localparam logic [14:0] PROG_LAST = 15'h07ff;
    localparam logic [14:0] RESET_VECTOR = 15'h0000;
    localparam logic [14:0] INT_VECTOR = 15'h0004;
    // Return stack
    localparam int STACK_DEPTH = 16;
    // Data address split
    localparam int DADDR_W = 12;
    localparam int OFS_W = 7;
    localparam int BANK_W = 5;
    // Core register offsets, region bounds and region sizes within every bank
    localparam logic [6:0] OFS_INDIRECT0 = 7'h00;
    localparam logic [6:0] OFS_INDIRECT1 = 7'h01;
    localparam logic [6:0] OFS_PC_LOW = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_PTR0_LOW = 7'h04;
    localparam logic [6:0] OFS_PTR0_HIGH = 7'h05;
    localparam logic [6:0] OFS_PTR1_LOW = 7'h06;
    localparam logic [6:0] OFS_PTR1_HIGH = 7'h07;
    localparam logic [6:0] OFS_BANK_SEL = 7'h08;
    localparam logic [6:0] OFS_ACCUM = 7'h09;
    localparam logic [6:0] OFS_PC_LATCH = 7'h0a;
    localparam logic [6:0] OFS_INT_CTRL = 7'h0b;
    localparam logic [6:0] OFS_PERIPH_FIRST = 7'h0c;
    localparam logic [6:0] OFS_PERIPH_LAST = 7'h1f;
    localparam logic [6:0] OFS_RAM_FIRST = 7'h20;
    localparam logic [6:0] OFS_RAM_LAST = 7'h6f;
    localparam logic [6:0] OFS_COMMON_FIRST = 7'h70;
    localparam int RAM_BYTES = 80;
    localparam int COMMON_BYTES = 16;
    // Status bit positions and reset value
    localparam int ST_TIMEOUT = 4;
    localparam int ST_POWERDOWN = 3;
    localparam int ST_ZERO = 2;
    localparam int ST_DIGIT = 1;
    localparam int ST_CARRY = 0;
    localparam logic [7:0] STATUS_POR = 8'h18;
    // Pointer high byte bit that selects program memory
    localparam int PTR_PROG_BIT = 7;
    // Linear window on general RAM for pointers
    localparam logic [3:0] LINEAR_TOP = 4'h2;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD = 4'h1,
        OP_SUB = 4'h2,
        OP_LOGIC = 4'h3,
        OP_ROT_LEFT = 4'h4,
        OP_ROT_RIGHT = 4'h5
    } alu_op_e;

    // Request from execution control for one data-space access
    typedef struct packed {
        logic rd;
        logic wr;
        logic indirect;
        logic ptr_sel;
        logic [6:0] ofs;
        logic [7:0] wdata;
    } data_req_s;

    // ALU operation and operands from which the flag outcome is formed
    typedef struct packed {
        logic [3:0] op;
        logic [7:0] a;
        logic [7:0] b;
    } alu_req_s;
endpackage

/* File: dv/exec_partner.sv */
// Program memory and peripheral stand-in on the far side of the core memory block
`timescale 1ns/100ps

module exec_partner (
    // Clock
    input wire logic CLK,
    // Program memory read port
    input wire logic PROG_RD,
    input wire logic [14:0] PROG_ADDR,
    output logic [13:0] PROG_DATA,
    // Peripheral window
    input wire logic [11:0] PERIPH_ADDR,
    output logic [7:0] PERIPH_RDATA
);
    logic [13:0] junk_reg = 14'h2aaa;

    // Outside a read the bus churns so a stale capture cannot pass
    always_ff @(posedge CLK)
    begin
        junk_reg <= ~junk_reg;
    end

    assign PROG_DATA = PROG_RD ? {6'h2a, PROG_ADDR[7:0] ^ 8'h3c} : junk_reg;
    assign PERIPH_RDATA = {PERIPH_ADDR[3:0], 4'h5};
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the core memory organisation block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; $display("[ERR] %s exp=%h got=%h", nm, exp, got); end end

module tb;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1;
    logic pc_adv = 1'b0, pc_load = 1'b0, int_take = 1'b0, call_push = 1'b0, ret_pop = 1'b0;
    logic stk_rst_en = 1'b0, clr_wdt = 1'b0, sleep = 1'b0, wdt_to = 1'b0;
    logic [14:0] pc_target = 15'h0000;
    core_mem_pkg::data_req_s dreq = '0;
    core_mem_pkg::alu_req_s alu = '0;
    logic [14:0] pc, prog_addr, last_paddr;
    logic stack_ovf, stack_unf, soft_reset, stall, prog_rd, periph_wr, last_stall, seen;
    logic [7:0] rdata, periph_wdata, periph_rdata, status, d;
    logic [11:0] periph_addr;
    logic [13:0] prog_data;
    int error_cnt = 0;
    int checks_done = 0;
    logic [3:0] t_op[8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h4};
    logic [7:0] t_a[8] = '{8'h0f, 8'hff, 8'h05, 8'h03, 8'h00, 8'h80, 8'h01, 8'h7f};
    logic [7:0] t_b[8] = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] t_exp[8] = '{8'h02, 8'h07, 8'h03, 8'h00, 8'h04, 8'h01, 8'h01, 8'h00};
    logic [7:0] t_msk[8] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h01, 8'h01, 8'h01};

    always #5 clk = ~clk;

    core_mem_org #(.RAM_BANKS(4)) u_core_mem_org (
        .CLK(clk), .RST(rst), .POR(por),
        .PC_ADVANCE(pc_adv), .PC_LOAD(pc_load), .PC_TARGET(pc_target),
        .INT_TAKE(int_take), .CALL_PUSH(call_push), .RET_POP(ret_pop),
        .STACK_RESET_EN(stk_rst_en), .PC(pc), .STACK_OVF(stack_ovf),
        .STACK_UNF(stack_unf), .SOFT_RESET(soft_reset),
        .DREQ(dreq), .RDATA(rdata), .STALL(stall),
        .PROG_RD(prog_rd), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
        .PERIPH_WR(periph_wr), .PERIPH_ADDR(periph_addr),
        .PERIPH_WDATA(periph_wdata), .PERIPH_RDATA(periph_rdata),
        .ALU(alu), .CLR_WDT(clr_wdt), .SLEEP(sleep), .WDT_TIMEOUT(wdt_to),
        .STATUS(status)
    );

    exec_partner u_exec_partner (
        .CLK(clk), .PROG_RD(prog_rd), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
        .PERIPH_ADDR(periph_addr), .PERIPH_RDATA(periph_rdata)
    );

    // The wr, rd and pulse tasks start and end on a falling edge
    task automatic wr(input logic ind, input logic ps, input logic [6:0] ofs, input logic [7:0] v);
        dreq = '{rd: 1'b0, wr: 1'b1, indirect: ind, ptr_sel: ps, ofs: ofs, wdata: v};
        @(negedge clk);
        dreq = '0;
    endtask

    task automatic rd(input logic ind, input logic ps, input logic [6:0] ofs, output logic [7:0] v);
        dreq = '{rd: 1'b1, wr: 1'b0, indirect: ind, ptr_sel: ps, ofs: ofs, wdata: 8'h00};
        @(negedge clk);
        dreq = '0;
        last_stall = stall;
        last_paddr = prog_addr;
        if (stall === 1'b1)
        begin
            @(negedge clk);
        end
        v = rdata;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        por = 1'b0;
        `CHK("pc_reset", 15'h0000, pc)
        `CHK("status_por", 8'h18, status)
        rd(1'b0, 1'b0, 7'h03, d);
        `CHK("status_read", 8'h18, d)
        pc_target = 15'h0805;
        pulse(pc_load);
        `CHK("pc_wrap_load", 15'h0005, pc)
        pc_target = 15'h07ff;
        pulse(pc_load);
        pulse(pc_adv);
        `CHK("pc_wrap_adv", 15'h0000, pc)
        pulse(int_take);
        `CHK("pc_int", 15'h0004, pc)
        pulse(ret_pop);
        `CHK("unf_early", 1'b0, stack_unf)
        pulse(ret_pop);
        `CHK("unf_set", 1'b1, stack_unf)
        pulse(rst);
        stk_rst_en = 1'b1;
        repeat (16) pulse(call_push);
        `CHK("ovf_at_16", 1'b0, stack_ovf)
        `CHK("soft_rst_idle", 1'b0, soft_reset)
        call_push = 1'b1;
        seen = 1'b0;
        repeat (4)
        begin
            @(negedge clk);
            call_push = 1'b0;
            if (soft_reset === 1'b1) seen = 1'b1;
        end
        `CHK("ovf_at_17", 1'b1, stack_ovf)
        `CHK("soft_rst", 1'b1, seen)
        stk_rst_en = 1'b0;
        pulse(rst);
        for (int b = 0; b < 4; b++)
        begin
            wr(1'b0, 1'b0, 7'h08, 8'(b));
            wr(1'b0, 1'b0, 7'h20, 8'ha0 + 8'(b));
        end
        for (int b = 0; b < 4; b++)
        begin
            wr(1'b0, 1'b0, 7'h08, 8'(b));
            rd(1'b0, 1'b0, 7'h20, d);
            `CHK("ram_bank", 8'ha0 + 8'(b), d)
        end
        wr(1'b0, 1'b0, 7'h7f, 8'h5c);
        wr(1'b0, 1'b0, 7'h08, 8'h00);
        rd(1'b0, 1'b0, 7'h7f, d);
        `CHK("common_ram", 8'h5c, d)
        wr(1'b0, 1'b0, 7'h09, 8'h3e);
        wr(1'b0, 1'b0, 7'h08, 8'h05);
        rd(1'b0, 1'b0, 7'h09, d);
        `CHK("accum_mirror", 8'h3e, d)
        rd(1'b0, 1'b0, 7'h08, d);
        `CHK("bank_mirror", 8'h05, d)
        wr(1'b0, 1'b0, 7'h08, 8'h1f);
        rd(1'b0, 1'b0, 7'h20, d);
        `CHK("unimpl_zero", 8'h00, d)
        wr(1'b0, 1'b0, 7'h08, 8'h02);
        wr(1'b0, 1'b0, 7'h0c, 8'h77);
        `CHK("periph_wr", 1'b1, periph_wr)
        `CHK("periph_addr", 12'h10c, periph_addr)
        `CHK("periph_wdata", 8'h77, periph_wdata)
        wr(1'b0, 1'b0, 7'h1f, 8'h66);
        `CHK("periph_last", 12'h11f, periph_addr)
        wr(1'b0, 1'b0, 7'h20, 8'h55);
        `CHK("ram_not_periph", 1'b0, periph_wr)
        wr(1'b0, 1'b0, 7'h06, 8'h75);
        wr(1'b0, 1'b0, 7'h07, 8'h00);
        wr(1'b1, 1'b1, 7'h01, 8'h9d);
        wr(1'b0, 1'b0, 7'h08, 8'h04);
        rd(1'b0, 1'b0, 7'h75, d);
        `CHK("ptr_data_wr", 8'h9d, d)
        wr(1'b0, 1'b0, 7'h04, 8'h23);
        wr(1'b0, 1'b0, 7'h05, 8'h81);
        rd(1'b1, 1'b0, 7'h00, d);
        `CHK("prog_stall", 1'b1, last_stall)
        `CHK("prog_addr", 15'h0123, last_paddr)
        `CHK("prog_low", 8'h23 ^ 8'h3c, d)
        wr(1'b1, 1'b0, 7'h00, 8'h11);
        rd(1'b1, 1'b0, 7'h00, d);
        `CHK("prog_no_wr", 8'h23 ^ 8'h3c, d)
        rd(1'b0, 1'b0, 7'h04, d);
        `CHK("ptr_kept", 8'h23, d)
        wr(1'b0, 1'b0, 7'h03, 8'hff);
        `CHK("status_ro", 8'h1f, status)
        alu = '{op: 4'h1, a: 8'h00, b: 8'h00};
        wr(1'b0, 1'b0, 7'h03, 8'h00);
        alu = '0;
        `CHK("status_alu_wins", 8'h1c, status)
        for (int i = 0; i < 8; i++)
        begin
            alu = '{op: t_op[i], a: t_a[i], b: t_b[i]};
            @(negedge clk);
            alu = '0;
            `CHK("alu_flags", t_exp[i], status & t_msk[i])
        end
        pulse(sleep);
        `CHK("sleep_flags", 2'b10, status[4:3])
        pulse(wdt_to);
        `CHK("wdt_flags", 2'b00, status[4:3])
        pulse(clr_wdt);
        `CHK("clear_watchdog_op_flags", 2'b11, status[4:3])
        summarize();
    end
endmodule
